/* include/pcl_defines.vh */
// constants for the per-channel link control block
`ifndef PCL_DEFINES_VH
`define PCL_DEFINES_VH

`define PCL_CLK_MHZ 20
`define PCL_LINK_TIMER_US 10000
`define PCL_LINK_TIMER_CYC (`PCL_LINK_TIMER_US * `PCL_CLK_MHZ)
`define PCL_SYNC_COMMAS 3
`define PCL_SYNC_ERRS 4
`define PCL_FIFO_DEPTH 4

`define PCL_ST1_LINK 2
`define PCL_ST1_AN_DONE 5
`define PCL_SV_SYNC 0
`define PCL_SV_LINK 1

`define PCL_ISOLATE_RST 1'b1
`define PCL_MGT_RESET_RST 1'b1

`endif

/* logic/pcl_fifo.v */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
module pcl_fifo #(
   parameter WIDTH = 10,
   parameter DEPTH = 4,
   parameter AW = 2
) (
   input wire clk,
   input wire rst_b,
   input wire ce,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_r;
   reg [AW-1:0] rd_ptr_r;
   reg [AW:0] count_r;
   wire push;
   wire pop;

   assign in_ready = (count_r != DEPTH[AW:0]);
   assign out_valid = (count_r != {(AW+1){1'b0}});
   assign out_data = mem_r[rd_ptr_r];
   assign push = in_valid & in_ready & ce;
   assign pop = out_valid & out_ready & ce;

   always @(posedge clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   always @(posedge clk) begin
      if (!rst_b) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
         end
         if (push & ~pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop & ~push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule

/* logic/pcl_channel_link.v */
// per-channel link establishment, isolate, auto-negotiation and status logic
//
// Overview of operation
// - transmit is blocked until link is up, unless the one-way transmit override is set.
// - isolate comes out of reset active; software must clear it before data flows.
// - while isolated, transmit input is ignored and receive outputs stay idle.
// - status register 1 bit 5 shows auto-negotiation complete.
// - a separate interrupt output flags auto-negotiation completion.
// - a bit error during the negotiation exchange restarts negotiation from the start.
// - negotiation completes only if the link partner also negotiates.
// - link status appears in status register 1 bit 2 and status vector bit 1.
// - status vector bit 0 is high once receive synchronization is acquired.
// - signal-present low holds receive synchronization in loss of sync.
// - transceiver resets stay asserted until the transceiver pll reports lock.
// - a line bit error inside a received frame is passed to the mac as receive error.
`timescale 1ns/1ns
`include "pcl_defines.vh"
module pcl_channel_link #(
   parameter LINK_TIMER_CYC = `PCL_LINK_TIMER_CYC,
   parameter TMR_W = 20,
   parameter FIFO_DEPTH = `PCL_FIFO_DEPTH,
   parameter FIFO_AW = 2
) (
   input wire CLOCK,
   input wire RST_B,
   input wire CE,
   input wire PLL_LOCKED,
   output wire MGT_TX_RESET,
   output wire MGT_RX_RESET,
   input wire SIGNAL_DETECT,
   input wire AN_ENABLE,
   input wire AN_RESTART,
   input wire UNIDIR_ENABLE,
   input wire ISOLATE_WE,
   input wire ISOLATE_WDATA,
   input wire AN_INT_ACK,
   output wire [15:0] STATUS_REG1,
   output wire [1:0] STATUS_VECTOR,
   output wire AN_INTERRUPT,
   output wire ISOLATE_STATE,
   input wire RX_COMMA,
   input wire RX_CODE_ERR,
   input wire RX_CONFIG,
   input wire RX_CONFIG_ACK,
   input wire RX_FRAME,
   input wire [7:0] RX_DATA,
   output wire LINE_TX_CONFIG,
   output wire LINE_TX_ACK,
   input wire [7:0] GMII_TXD,
   input wire GMII_TX_EN,
   input wire GMII_TX_ER,
   output wire GMII_TX_READY,
   output wire [7:0] GMII_RXD,
   output wire GMII_RX_DV,
   output wire GMII_RX_ER,
   output wire LINE_TX_VALID,
   input wire LINE_TX_READY,
   output wire [7:0] LINE_TXD,
   output wire LINE_TX_EN,
   output wire LINE_TX_ER
);
   // receive synchronization states
   localparam [2:0] SY_LOSS = 3'b001;
   localparam [2:0] SY_DET = 3'b010;
   localparam [2:0] SY_OK = 3'b100;
   // auto-negotiation states
   localparam [4:0] AN_RST = 5'b00001;
   localparam [4:0] AN_ABIL = 5'b00010;
   localparam [4:0] AN_ACKD = 5'b00100;
   localparam [4:0] AN_CMPL = 5'b01000;
   localparam [4:0] AN_LINK = 5'b10000;
   localparam [TMR_W-1:0] TMR_END = LINK_TIMER_CYC[TMR_W-1:0] - 1'b1;
   localparam integer COMMAS_N = `PCL_SYNC_COMMAS - 1;
   localparam integer ERRS_N = `PCL_SYNC_ERRS - 1;
   localparam [1:0] COMMAS_END = COMMAS_N[1:0];
   localparam [2:0] ERRS_END = ERRS_N[2:0];

   reg mgt_reset_r;
   reg isolate_r;
   reg isolate_nxt;
   reg [2:0] sy_state_r;
   reg [2:0] sy_state_nxt;
   reg [1:0] comma_cnt_r;
   reg [1:0] comma_cnt_nxt;
   reg [2:0] err_cnt_r;
   reg [2:0] err_cnt_nxt;
   reg [4:0] an_state_r;
   reg [4:0] an_state_nxt;
   reg [TMR_W-1:0] tmr_r;
   reg [TMR_W-1:0] tmr_nxt;
   reg an_int_r;
   reg an_done_d_r;
   reg [7:0] rxd_r;
   reg rx_dv_r;
   reg rx_er_r;
   wire sync_ok;
   wire an_done;
   wire link_up;
   wire tx_allow;
   wire tx_write;
   wire fifo_in_ready;
   wire [9:0] fifo_out;
   wire tmr_done;
   wire an_exchange;

   // transceiver reset held until the pll locks
   always @(posedge CLOCK) begin
      if (!RST_B) begin
         mgt_reset_r <= `PCL_MGT_RESET_RST;
      end else if (CE) begin
         mgt_reset_r <= ~PLL_LOCKED;
      end
   end
   assign MGT_TX_RESET = mgt_reset_r;
   assign MGT_RX_RESET = mgt_reset_r;

   // isolate control: active from reset, written by software
   always @* begin
      isolate_nxt = isolate_r;
      if (ISOLATE_WE) begin
         isolate_nxt = ISOLATE_WDATA;
      end
   end

   always @(posedge CLOCK) begin
      if (!RST_B) begin
         isolate_r <= `PCL_ISOLATE_RST;
      end else if (CE) begin
         isolate_r <= isolate_nxt;
      end
   end
   assign ISOLATE_STATE = isolate_r;

   // receive synchronization
   always @* begin
      sy_state_nxt = sy_state_r;
      comma_cnt_nxt = comma_cnt_r;
      err_cnt_nxt = err_cnt_r;
      case (sy_state_r)
         SY_LOSS: begin
            comma_cnt_nxt = 2'h0;
            err_cnt_nxt = 3'h0;
            if (RX_COMMA & ~RX_CODE_ERR) begin
               sy_state_nxt = SY_DET;
            end
         end
         SY_DET: begin
            if (RX_CODE_ERR) begin
               sy_state_nxt = SY_LOSS;
            end else if (RX_COMMA) begin
               if (comma_cnt_r == COMMAS_END - 2'h1) begin
                  sy_state_nxt = SY_OK;
                  comma_cnt_nxt = 2'h0;
               end else begin
                  comma_cnt_nxt = comma_cnt_r + 2'h1;
               end
            end
         end
         SY_OK: begin
            if (RX_CODE_ERR) begin
               if (err_cnt_r == ERRS_END) begin
                  sy_state_nxt = SY_LOSS;
               end else begin
                  err_cnt_nxt = err_cnt_r + 3'h1;
               end
            end else if (RX_COMMA) begin
               err_cnt_nxt = 3'h0;
            end
         end
         default: begin
            sy_state_nxt = SY_LOSS;
         end
      endcase
      if (!SIGNAL_DETECT || mgt_reset_r) begin
         sy_state_nxt = SY_LOSS;
      end
   end

   always @(posedge CLOCK) begin
      if (!RST_B) begin
         sy_state_r <= SY_LOSS;
         comma_cnt_r <= 2'h0;
         err_cnt_r <= 3'h0;
      end else if (CE) begin
         sy_state_r <= sy_state_nxt;
         comma_cnt_r <= comma_cnt_nxt;
         err_cnt_r <= err_cnt_nxt;
      end
   end
   assign sync_ok = (sy_state_r == SY_OK);

   // auto-negotiation exchange, timed by the link timer
   assign tmr_done = (tmr_r == TMR_END);
   assign an_exchange = (an_state_r != AN_LINK);

   always @* begin
      an_state_nxt = an_state_r;
      tmr_nxt = tmr_done ? tmr_r : tmr_r + {{(TMR_W-1){1'b0}}, 1'b1};
      case (an_state_r)
         AN_RST: begin
            if (tmr_done) begin
               an_state_nxt = AN_ABIL;
               tmr_nxt = {TMR_W{1'b0}};
            end
         end
         AN_ABIL: begin
            // only a partner that negotiates sends config sets
            if (RX_CONFIG) begin
               an_state_nxt = AN_ACKD;
            end
         end
         AN_ACKD: begin
            if (!RX_CONFIG) begin
               an_state_nxt = AN_ABIL;
            end else if (RX_CONFIG_ACK) begin
               an_state_nxt = AN_CMPL;
               tmr_nxt = {TMR_W{1'b0}};
            end
         end
         AN_CMPL: begin
            if (!RX_CONFIG_ACK) begin
               an_state_nxt = AN_RST;
               tmr_nxt = {TMR_W{1'b0}};
            end else if (tmr_done) begin
               an_state_nxt = AN_LINK;
            end
         end
         AN_LINK: begin
            if (!sync_ok) begin
               an_state_nxt = AN_RST;
               tmr_nxt = {TMR_W{1'b0}};
            end
         end
         default: begin
            an_state_nxt = AN_RST;
            tmr_nxt = {TMR_W{1'b0}};
         end
      endcase
      if (an_exchange && RX_CODE_ERR) begin
         an_state_nxt = AN_RST;
         tmr_nxt = {TMR_W{1'b0}};
      end
      if (AN_RESTART || !AN_ENABLE || !sync_ok) begin
         an_state_nxt = AN_RST;
         tmr_nxt = {TMR_W{1'b0}};
      end
   end

   always @(posedge CLOCK) begin
      if (!RST_B) begin
         an_state_r <= AN_RST;
         tmr_r <= {TMR_W{1'b0}};
      end else if (CE) begin
         an_state_r <= an_state_nxt;
         tmr_r <= tmr_nxt;
      end
   end

   // completion drops in the same cycle as sync, so it never outlives the link
   assign an_done = AN_ENABLE & sync_ok & (an_state_r == AN_LINK);
   assign LINE_TX_CONFIG = AN_ENABLE & an_exchange;
   assign LINE_TX_ACK = AN_ENABLE & ((an_state_r == AN_ACKD) | (an_state_r == AN_CMPL));

   // completion interrupt: sticky, set wins over acknowledge
   always @(posedge CLOCK) begin
      if (!RST_B) begin
         an_int_r <= 1'b0;
         an_done_d_r <= 1'b0;
      end else if (CE) begin
         an_done_d_r <= an_done;
         if (an_done & ~an_done_d_r) begin
            an_int_r <= 1'b1;
         end else if (AN_INT_ACK) begin
            an_int_r <= 1'b0;
         end
      end
   end
   assign AN_INTERRUPT = an_int_r;

   // link status; with negotiation off, sync alone makes the link
   assign link_up = sync_ok & (an_done | ~AN_ENABLE);
   assign STATUS_VECTOR[`PCL_SV_SYNC] = sync_ok;
   assign STATUS_VECTOR[`PCL_SV_LINK] = link_up;

   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_st1
         if (gi == `PCL_ST1_LINK) begin : g_link
            assign STATUS_REG1[gi] = link_up;
         end else if (gi == `PCL_ST1_AN_DONE) begin : g_an
            assign STATUS_REG1[gi] = an_done;
         end else begin : g_zero
            assign STATUS_REG1[gi] = 1'b0;
         end
      end
   endgenerate

   // transmit path gated by link, override and isolate
   assign tx_allow = (link_up | UNIDIR_ENABLE) & ~isolate_r;
   assign tx_write = tx_allow & (GMII_TX_EN | GMII_TX_ER);
   assign GMII_TX_READY = fifo_in_ready & tx_allow;

   pcl_fifo #(
      .WIDTH(10),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_tx_fifo (
      .clk(CLOCK),
      .rst_b(RST_B),
      .ce(CE),
      .in_valid(tx_write),
      .in_ready(fifo_in_ready),
      .in_data({GMII_TX_ER, GMII_TX_EN, GMII_TXD}),
      .out_valid(LINE_TX_VALID),
      .out_ready(LINE_TX_READY),
      .out_data(fifo_out)
   );
   assign LINE_TXD = fifo_out[7:0];
   assign LINE_TX_EN = fifo_out[8];
   assign LINE_TX_ER = fifo_out[9];

   // receive path toward the mac
   always @(posedge CLOCK) begin
      if (!RST_B) begin
         rxd_r <= 8'h00;
         rx_dv_r <= 1'b0;
         rx_er_r <= 1'b0;
      end else if (CE) begin
         if (isolate_r || !sync_ok) begin
            rxd_r <= 8'h00;
            rx_dv_r <= 1'b0;
            rx_er_r <= 1'b0;
         end else begin
            rxd_r <= RX_FRAME ? RX_DATA : 8'h00;
            rx_dv_r <= RX_FRAME;
            rx_er_r <= RX_FRAME & RX_CODE_ERR;
         end
      end
   end
   assign GMII_RXD = rxd_r;
   assign GMII_RX_DV = rx_dv_r;
   assign GMII_RX_ER = rx_er_r;
endmodule

/* tb/pcl_link_sva.sv */
// assertion checker for the channel link block
`timescale 1ns/1ns
module pcl_link_sva #(
   parameter LINK_TIMER_CYC = 8
) (
   input wire CLOCK,
   input wire RST_B,
   input wire PLL_LOCKED,
   input wire MGT_TX_RESET,
   input wire MGT_RX_RESET,
   input wire SIGNAL_DETECT,
   input wire AN_ENABLE,
   input wire UNIDIR_ENABLE,
   input wire RX_FRAME,
   input wire RX_CODE_ERR,
   input wire [15:0] STATUS_REG1,
   input wire [1:0] STATUS_VECTOR,
   input wire AN_INTERRUPT,
   input wire ISOLATE_STATE,
   input wire GMII_TX_READY,
   input wire GMII_RX_DV,
   input wire GMII_RX_ER
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_B);
   sequence s_neg_err;
      AN_ENABLE && !STATUS_REG1[5] && RX_CODE_ERR;
   endsequence
   sequence s_held_off;
      !STATUS_REG1[5] [*8];
   endsequence
   a_reset_state: assert property ($rose(RST_B) |-> ISOLATE_STATE && MGT_TX_RESET && !AN_INTERRUPT)
      else $error("state after reset wrong");
   a_pll_hold: assert property (!PLL_LOCKED |=> MGT_TX_RESET && MGT_RX_RESET)
      else $error("transceiver reset released without lock");
   a_pll_release: assert property (PLL_LOCKED [*2] |-> !MGT_TX_RESET && !MGT_RX_RESET)
      else $error("transceiver reset held after lock");
   a_tx_gate: assert property (GMII_TX_READY |-> (STATUS_VECTOR[1] || UNIDIR_ENABLE) && !ISOLATE_STATE)
      else $error("transmit accepted while not allowed");
   a_iso_rx: assert property (ISOLATE_STATE |=> !GMII_RX_DV && !GMII_RX_ER)
      else $error("receive output while isolated");
   a_sd_loss: assert property (!SIGNAL_DETECT |-> ##[1:2] !STATUS_VECTOR[0])
      else $error("sync kept without signal");
   a_link_mirror: assert property (STATUS_REG1[2] == STATUS_VECTOR[1])
      else $error("link bits disagree");
   a_done_link: assert property (STATUS_REG1[5] |-> STATUS_REG1[2])
      else $error("negotiation done without link");
   a_int_set: assert property ($rose(STATUS_REG1[5]) |=> AN_INTERRUPT)
      else $error("no interrupt on completion");
   a_err_restart: assert property (s_neg_err |=> s_held_off)
      else $error("negotiation not restarted on error");
   a_rx_err: assert property (RX_FRAME && RX_CODE_ERR && STATUS_VECTOR[0] && !ISOLATE_STATE |=> GMII_RX_ER)
      else $error("frame error not passed on");
endmodule
bind pcl_channel_link pcl_link_sva #(.LINK_TIMER_CYC(LINK_TIMER_CYC)) sva_u (.*);

/* tb/pcl_partner.sv */
// link partner model driving the receive line indications
`timescale 1ns/1ns
module pcl_partner (
   input wire clk,
   input wire an_on,
   input wire tx_cfg,
   output reg comma,
   output reg code_err,
   output reg cfg,
   output reg cfg_ack,
   output reg frame,
   output reg [7:0] data
);
   reg [9:0] q[$];
   reg [9:0] e;
   reg hit;
   reg on;
   // entry: frame flag, error flag, byte
   task put(input [9:0] v);
      q.push_back(v);
   endtask
   initial begin
      {comma, code_err, cfg, cfg_ack, frame, data} = 0;
   end
   // queue and enable are taken at the edge, so puts made just after the previous edge never race
   always @(posedge clk) begin
      on = an_on;
      hit = (q.size() > 0);
      if (hit) begin
         e = q.pop_front();
      end
      #1;
      cfg = on;
      cfg_ack = on && tx_cfg;
      if (hit) begin
         {frame, code_err, data} = e;
         comma = 1'b0;
      end else begin
         {frame, code_err, comma} = 3'b001;
         data = ~data;
      end
   end
endmodule

/* tb/pcl_channel_link_tb.sv */
// self-checking bench for the channel link block
`timescale 1ns/1ns
module pcl_channel_link_tb;
   reg CLOCK = 0, RST_B = 0, CE = 1, PLL_LOCKED = 0, SIGNAL_DETECT = 0, AN_ENABLE = 0, AN_RESTART = 0;
   reg UNIDIR_ENABLE = 0, ISOLATE_WE = 0, ISOLATE_WDATA = 0, AN_INT_ACK = 0, GMII_TX_EN = 0;
   reg GMII_TX_ER = 0, LINE_TX_READY = 0, p_an = 0;
   reg [7:0] GMII_TXD = 0;
   wire MGT_TX_RESET, MGT_RX_RESET, AN_INTERRUPT, ISOLATE_STATE, LINE_TX_CONFIG, LINE_TX_ACK;
   wire GMII_TX_READY, GMII_RX_DV, GMII_RX_ER, LINE_TX_VALID, LINE_TX_EN, LINE_TX_ER;
   wire RX_COMMA, RX_CODE_ERR, RX_CONFIG, RX_CONFIG_ACK, RX_FRAME;
   wire [7:0] RX_DATA, GMII_RXD, LINE_TXD;
   wire [15:0] STATUS_REG1;
   wire [1:0] STATUS_VECTOR;
   integer n_errors = 0, tests_run = 0, i, n;
   always #25 CLOCK = ~CLOCK;
   pcl_channel_link #(.LINK_TIMER_CYC(8)) dut_u (.*);
   pcl_partner p_u (.clk(CLOCK), .an_on(p_an), .tx_cfg(LINE_TX_CONFIG), .comma(RX_COMMA),
      .code_err(RX_CODE_ERR), .cfg(RX_CONFIG), .cfg_ack(RX_CONFIG_ACK), .frame(RX_FRAME), .data(RX_DATA));
   task chk(input [15:0] got, input [15:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task cyc(input integer c);
      begin
         repeat (c) @(posedge CLOCK);
         #1;
      end
   endtask
   task wr_iso(input v);
      begin
         ISOLATE_WE = 1;
         ISOLATE_WDATA = v;
         cyc(1);
         ISOLATE_WE = 0;
      end
   endtask
   task wait_done;
      begin
         n = 0;
         while (STATUS_REG1[5] !== 1'b1 && n < 60) begin
            cyc(1);
            n = n + 1;
         end
      end
   endtask
   task test_done;
      begin
         $display("errors=%0d checks=%0d", n_errors, tests_run);
         if (n_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   initial begin
      repeat (5000) @(posedge CLOCK);
      n_errors = n_errors + 1;
      test_done;
   end
   initial begin
      cyc(12);
      RST_B = 1;
      cyc(1);
      chk({ISOLATE_STATE, MGT_TX_RESET, GMII_TX_READY}, 3'b110);
      cyc(3);
      chk(MGT_RX_RESET, 1);
      PLL_LOCKED = 1;
      cyc(2);
      chk({MGT_TX_RESET, MGT_RX_RESET}, 0);
      cyc(20);
      chk(STATUS_VECTOR, 0);
      SIGNAL_DETECT = 1;
      cyc(8);
      chk(STATUS_VECTOR, 3);
      chk(STATUS_REG1, 16'h0004);
      chk(GMII_TX_READY, 0);
      p_u.put(10'h25a);
      cyc(2);
      chk(GMII_RX_DV, 0);
      wr_iso(0);
      chk(ISOLATE_STATE, 0);
      n = 0;
      for (i = 0; i < 6; i = i + 1) begin
         GMII_TXD = 8'h10 + i;
         GMII_TX_EN = 1;
         GMII_TX_ER = (i == 1);
         n = n + GMII_TX_READY;
         cyc(1);
      end
      GMII_TX_EN = 0;
      GMII_TX_ER = 0;
      chk(n, 4);
      LINE_TX_READY = 1;
      for (i = 0; i < 4; i = i + 1) begin
         chk({LINE_TX_VALID, LINE_TX_ER, LINE_TX_EN, LINE_TXD}, {1'b1, i == 1, 1'b1, 8'h10 + i[7:0]});
         cyc(1);
      end
      chk(LINE_TX_VALID, 0);
      p_u.put(10'h233);
      p_u.put(10'h344);
      cyc(2);
      chk({GMII_RX_DV, GMII_RX_ER, GMII_RXD}, 10'h233);
      cyc(1);
      chk({GMII_RX_DV, GMII_RX_ER, GMII_RXD}, 10'h344);
      SIGNAL_DETECT = 0;
      cyc(4);
      chk(GMII_TX_READY, 0);
      UNIDIR_ENABLE = 1;
      cyc(1);
      chk(GMII_TX_READY, 1);
      UNIDIR_ENABLE = 0;
      CE = 0;
      wr_iso(1);
      chk(ISOLATE_STATE, 0);
      CE = 1;
      SIGNAL_DETECT = 1;
      AN_ENABLE = 1;
      cyc(60);
      chk(STATUS_REG1[5], 0);
      chk({LINE_TX_CONFIG, LINE_TX_ACK}, 2'b10);
      p_an = 1;
      wait_done;
      chk(STATUS_REG1, 16'h0024);
      chk({LINE_TX_CONFIG, LINE_TX_ACK}, 2'b00);
      cyc(1);
      chk(AN_INTERRUPT, 1);
      AN_INT_ACK = 1;
      AN_RESTART = 1;
      cyc(1);
      {AN_INT_ACK, AN_RESTART} = 0;
      cyc(1);
      chk({STATUS_REG1[5], AN_INTERRUPT}, 0);
      cyc(10);
      chk({LINE_TX_CONFIG, LINE_TX_ACK}, 2'b11);
      p_u.put(10'h100);
      cyc(14);
      chk(STATUS_REG1[5], 0);
      wait_done;
      chk(STATUS_REG1[5], 1);
      test_done;
   end
endmodule
